// file: hdl/flash_cfg_pkg.sv
package flash_cfg_pkg;

    // ------------------------------------------------------------------
    // Widths and mode encodings.
    // ------------------------------------------------------------------
    localparam int ADDR_W_FULL = 24;
    localparam int ADDR_W_SMALL = 20;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [2:0] MODE_FLASH_UP = 3'h2;
    localparam logic [2:0] MODE_FLASH_DOWN = 3'h3;

    // ------------------------------------------------------------------
    // Timing: configuration clock divider and memory clearing time.
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int CFG_CLK_HALF_CYC = 2;
    localparam int CLEAR_TIME_NS = 1000;
    localparam int CLEAR_CYC = (CLEAR_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;

    // ------------------------------------------------------------------
    // Configuration sequence states.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CLEAR = 3'b001,
        ST_LOAD = 3'b010,
        ST_DONE = 3'b011,
        ST_FAIL = 3'b100
    } cfg_state_t;

endpackage

// file: hdl/flash_cfg_master.sv
// Operation
// R1 - Mode input 010 or 011 selects loading from the byte-wide parallel flash.
// R2 - Flash address bus up to 24 bits is driven during loading.
// R3 - Address width is a parameter; small package uses 20 lines.
// R4 - Attached flash must be 8-bit or 8/16-bit used in 8-bit mode.
// R5 - Internal clock times flash cycles and is driven on the clock pin.
// R6 - Direction input 0: start at zero, increment on each falling clock edge; the code does not increment on the first falling edge after loading starts.
// R7 - Direction input 1: start at all ones, decrement on each falling edge; the code does not decrement on the first falling edge after loading starts.
// R8 - Mode inputs sampled when init status rises; board holds them valid.
// R9 - After done rises, mode pins are released to user I/O.
// R10 - Pull-up select low enables pull-ups; held constant during loading.
// R11 - Board holds read/write select and chip select low throughout loading.
// R12 - Chip select out, clock out and busy are actively driven during loading.
// R13 - After loading, flash pins are released except done and program request.
// R14 - Keep-port option keeps the parallel port active after loading.
// R15 - Flash chip enable driven low throughout loading.
// R16 - Flash output enable driven low throughout loading.
// R17 - Flash write enable driven high throughout loading.
// R18 - Flash byte mode held low during loading; user may drive high later.
// R19 - Only the device or a sharing processor boots from the flash at once.
// R20 - One data byte is taken per presented address.
// R21 - Init status low while clearing, released at end of clearing.
// R22 - A CRC error drives init status low.
// R23 - Data sampled once per clock cycle after the address settled.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Byte FIFO between flash reads and the configuration consumer.
// ----------------------------------------------------------------------
module cfg_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_t;

    fifo_t s_q;
    fifo_t s_d;
    logic push;
    logic pop;

    // Handshakes are combinational from the fill count.
    assign o_in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_q.cnt != '0);
    assign o_out_data = s_q.mem[s_q.rd];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer and count update; storage holds its value when idle.
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = i_in_data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // cfg_byte_fifo

// ----------------------------------------------------------------------
// Flash configuration master.
// ----------------------------------------------------------------------
module flash_cfg_master #(
    parameter int ADDR_W = flash_cfg_pkg::ADDR_W_FULL
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_program_request_n,
    input wire logic [2:0] i_mode_select,
    input wire logic i_pullup_disable_select,
    input wire logic i_readwrite_select_n,
    input wire logic i_chip_select_in_n,
    input wire logic i_keep_parallel_port,
    input wire logic [7:0] i_flash_data,
    input wire logic i_crc_error,
    input wire logic i_load_finished,
    output logic [ADDR_W-1:0] o_flash_addr,
    output logic o_flash_pins_oe,
    output logic o_flash_chip_enable_n,
    output logic o_flash_output_enable_n,
    output logic o_flash_write_enable_n,
    output logic o_flash_byte_mode_n,
    output logic o_config_clock_out,
    output logic o_chip_select_out_n,
    output logic o_busy,
    output logic o_init_status_n_out,
    output logic o_init_status_oe,
    output logic o_done,
    output logic o_mode_pins_user,
    output logic o_pullups_enable,
    output logic o_parallel_port_active,
    output logic [7:0] o_cfg_data,
    output logic o_cfg_valid,
    input wire logic i_cfg_ready
);
    localparam int HW = $clog2(flash_cfg_pkg::CFG_CLK_HALF_CYC + 1);
    localparam int CW = $clog2(flash_cfg_pkg::CLEAR_CYC + 1);

    typedef struct packed {
        logic prog_s1;
        logic prog_s2;
        logic [2:0] mode_s1;
        logic [2:0] mode_s2;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [7:0] data_s1;
        logic [7:0] data_s2;
        flash_cfg_pkg::cfg_state_t st;
        logic [CW-1:0] clr_cnt;
        logic [HW-1:0] half;
        logic config_clock_out;
        logic down;
        logic pullup_dis;
        logic [ADDR_W-1:0] addr;
        logic settled;
        logic [7:0] byte_q;
        logic byte_v;
    } master_t;

    master_t s_q;
    master_t s_d;
    logic fifo_in_ready;
    logic config_clock_out_fall;
    logic loading;

    // Two-stage synchronisers: only stage two is read by logic.
    logic prog_n_s;
    logic rw_n_s;
    logic cs_n_s;
    logic [2:0] mode_s;
    logic [7:0] data_s;
    assign prog_n_s = s_q.prog_s2;
    assign mode_s = s_q.mode_s2;
    assign rw_n_s = s_q.pin_s2[0];
    assign cs_n_s = s_q.pin_s2[1];
    assign data_s = s_q.data_s2;

    assign loading = (s_q.st == flash_cfg_pkg::ST_LOAD);
    assign config_clock_out_fall = loading && s_q.config_clock_out &&
        (s_q.half == HW'(flash_cfg_pkg::CFG_CLK_HALF_CYC - 1));

    // Sequencer: clear, sample mode, walk the flash, finish or fail.
    always_comb begin
        s_d = s_q;
        s_d.prog_s1 = i_program_request_n;
        s_d.prog_s2 = s_q.prog_s1;
        s_d.mode_s1 = i_mode_select;
        s_d.mode_s2 = s_q.mode_s1;
        s_d.pin_s1 = {i_chip_select_in_n, i_readwrite_select_n};
        s_d.pin_s2 = s_q.pin_s1;
        s_d.data_s1 = i_flash_data;
        s_d.data_s2 = s_q.data_s1;
        if (s_q.byte_v && fifo_in_ready) begin
            s_d.byte_v = 1'b0;
        end
        case (s_q.st)
            flash_cfg_pkg::ST_IDLE: begin
                s_d.clr_cnt = '0;
                s_d.pullup_dis = i_pullup_disable_select; // see R10
                if (prog_n_s) begin
                    s_d.st = flash_cfg_pkg::ST_CLEAR;
                end
            end
            flash_cfg_pkg::ST_CLEAR: begin
                // Init stays low while clearing runs.
                s_d.clr_cnt = s_q.clr_cnt + 1'b1; // see R21
                if (s_q.clr_cnt == CW'(flash_cfg_pkg::CLEAR_CYC - 1)) begin
                    // Mode pins are sampled on the edge that releases init.
                    if (mode_s == flash_cfg_pkg::MODE_FLASH_UP ||
                        mode_s == flash_cfg_pkg::MODE_FLASH_DOWN) begin // see R1 see R8
                        s_d.st = flash_cfg_pkg::ST_LOAD;
                        s_d.down = mode_s[0];
                        s_d.addr = mode_s[0] ? '1 : '0; // see R6 see R7
                        s_d.half = '0;
                        s_d.config_clock_out = 1'b1;
                        s_d.settled = 1'b0;
                    end else begin
                        // A refused mode never starts the clock, so no runt pulse leaks out.
                        s_d.st = flash_cfg_pkg::ST_FAIL;
                        s_d.config_clock_out = 1'b0;
                    end
                end
            end
            flash_cfg_pkg::ST_LOAD: begin
                // Divider for the configuration clock; a full FIFO stalls it.
                if (!s_q.byte_v || fifo_in_ready) begin
                    if (s_q.half == HW'(flash_cfg_pkg::CFG_CLK_HALF_CYC - 1)) begin
                        s_d.half = '0;
                        s_d.config_clock_out = !s_q.config_clock_out; // see R5
                    end else begin
                        s_d.half = s_q.half + 1'b1;
                    end
                end
                if (config_clock_out_fall) begin
                    // Byte for the address held one full cycle is taken here.
                    if (s_q.settled && rw_n_s == 1'b0 && cs_n_s == 1'b0) begin // see R11
                        s_d.byte_q = data_s; // see R20 see R23
                        s_d.byte_v = 1'b1;
                    end
                    if (s_q.settled) begin
                        s_d.addr = s_q.down ? s_q.addr - 1'b1 : s_q.addr + 1'b1; // see R6 see R7
                    end
                    s_d.settled = 1'b1;
                end
                if (i_crc_error) begin
                    s_d.st = flash_cfg_pkg::ST_FAIL; // see R22
                end else if (i_load_finished) begin
                    s_d.st = flash_cfg_pkg::ST_DONE;
                end
            end
            flash_cfg_pkg::ST_DONE: begin
                s_d.config_clock_out = 1'b0;
            end
            flash_cfg_pkg::ST_FAIL: begin
                s_d.config_clock_out = 1'b0;
            end
            default: begin
                s_d.st = flash_cfg_pkg::ST_IDLE;
            end
        endcase
        // A program request restarts the whole sequence at once.
        if (!prog_n_s) begin
            s_d.st = flash_cfg_pkg::ST_IDLE;
            s_d.byte_v = 1'b0;
            // Stop the clock at once so a cut load leaves it parked low.
            s_d.config_clock_out = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Bytes pass through the FIFO so a slow consumer stalls the flash walk.
    cfg_byte_fifo #(
        .WIDTH(flash_cfg_pkg::DATA_W),
        .DEPTH(flash_cfg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_in_valid(s_q.byte_v),
        .o_in_ready(fifo_in_ready),
        .i_in_data(s_q.byte_q),
        .o_out_valid(o_cfg_valid),
        .i_out_ready(i_cfg_ready),
        .o_out_data(o_cfg_data)
    );

    // Pin drive: static strobes during loading, released afterwards.
    assign o_flash_addr = s_q.addr; // see R2 see R3
    assign o_flash_pins_oe = loading; // see R12 see R13
    assign o_flash_chip_enable_n = 1'b0; // see R15
    assign o_flash_output_enable_n = 1'b0; // see R16
    assign o_flash_write_enable_n = 1'b1; // see R17
    assign o_flash_byte_mode_n = 1'b0; // see R18
    assign o_config_clock_out = s_q.config_clock_out; // see R5 see R12
    assign o_chip_select_out_n = 1'b1; // see R12
    assign o_busy = 1'b0; // see R12
    // Init is open drain: driven low while idle or clearing, or after a failure.
    assign o_init_status_n_out = 1'b0;
    assign o_init_status_oe = (s_q.st == flash_cfg_pkg::ST_IDLE) ||
        (s_q.st == flash_cfg_pkg::ST_CLEAR) ||
        (s_q.st == flash_cfg_pkg::ST_FAIL); // see R21 see R22
    assign o_done = (s_q.st == flash_cfg_pkg::ST_DONE);
    assign o_mode_pins_user = o_done; // see R9 see R13
    assign o_pullups_enable = !s_q.pullup_dis && !o_done; // see R10
    assign o_parallel_port_active = o_done && i_keep_parallel_port; // see R14
endmodule // flash_cfg_master

`default_nettype wire

// file: verif/flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Byte-wide parallel flash seen from the configuration master.
// ----------------------------------------------------------------------
module flash_model #(
    parameter int ADDR_W = 24
) (
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    output logic [7:0] o_data
);
    // One byte per address; a deselected part shows a flipped pattern, not stale data.
    always_comb begin
        if (!i_ce_n && !i_oe_n) begin
            o_data = i_addr[7:0] ^ 8'h3c;
        end else begin
            o_data = ~(i_addr[7:0] ^ 8'h3c);
        end
    end
endmodule // flash_model
`default_nettype wire

// file: verif/flash_cfg_master_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the flash configuration master.
// ----------------------------------------------------------------------
module flash_cfg_master_chk #(
    parameter int ADDR_W = 24
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_keep_parallel_port,
    input wire logic i_crc_error,
    input wire logic i_load_finished,
    input wire logic [ADDR_W-1:0] o_flash_addr,
    input wire logic o_flash_pins_oe,
    input wire logic o_flash_chip_enable_n,
    input wire logic o_flash_output_enable_n,
    input wire logic o_flash_write_enable_n,
    input wire logic o_flash_byte_mode_n,
    input wire logic o_config_clock_out,
    input wire logic o_init_status_oe,
    input wire logic o_done,
    input wire logic o_mode_pins_user,
    input wire logic o_pullups_enable,
    input wire logic o_parallel_port_active
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // Strobes must stay static while the flash is being read.
    ce_held_low_a: assert property (o_flash_pins_oe |-> !o_flash_chip_enable_n)
        else $error("flash chip enable high while loading");
    oe_held_low_a: assert property (o_flash_pins_oe |-> !o_flash_output_enable_n)
        else $error("flash output enable high while loading");
    we_held_high_a: assert property (o_flash_pins_oe |-> o_flash_write_enable_n)
        else $error("flash write enable low while loading");
    byte_mode_low_a: assert property (o_flash_pins_oe |-> !o_flash_byte_mode_n)
        else $error("flash byte mode high while loading");
    // The address may only move on a falling configuration clock edge.
    addr_hold_a: assert property (o_flash_pins_oe && $past(o_flash_pins_oe) &&
        !$fell(o_config_clock_out) |-> $stable(o_flash_addr)) else $error("address moved early");
    config_clock_out_high_a: assert property ($rose(o_config_clock_out) && !i_load_finished &&
        !i_crc_error |=> o_config_clock_out) else $error("clock high phase too short");
    crc_fail_a: assert property (o_flash_pins_oe && i_crc_error |=>
        o_init_status_oe && !o_done) else $error("crc error not flagged");
    init_release_a: assert property (o_flash_pins_oe |-> !o_init_status_oe)
        else $error("init status held low while loading");
    pins_release_a: assert property (o_done |-> !o_flash_pins_oe && o_mode_pins_user)
        else $error("pins not released after done");
    pullup_off_a: assert property (o_done |-> !o_pullups_enable)
        else $error("pull-ups on after done");
    port_keep_a: assert property (o_parallel_port_active == (o_done && i_keep_parallel_port))
        else $error("parallel port state wrong");
    cover property ($rose(o_done));
    cover property (o_flash_pins_oe && $fell(o_config_clock_out));
    cover property (o_flash_pins_oe && i_crc_error);
endmodule // flash_cfg_master_chk
bind flash_cfg_master flash_cfg_master_chk #(.ADDR_W(ADDR_W)) chk_u (.i_clk, .i_srst,
    .i_keep_parallel_port, .i_crc_error, .i_load_finished, .o_flash_addr, .o_flash_pins_oe,
    .o_flash_chip_enable_n, .o_flash_output_enable_n, .o_flash_write_enable_n,
    .o_flash_byte_mode_n, .o_config_clock_out, .o_init_status_oe, .o_done,
    .o_mode_pins_user, .o_pullups_enable, .o_parallel_port_active);
`default_nettype wire

// file: verif/test_flash_cfg_master.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench: loads in both directions, consumer stall, restart, failures.
// ----------------------------------------------------------------------
module test_flash_cfg_master;
    localparam int AW = flash_cfg_pkg::ADDR_W_SMALL;
    logic clk, srst, prog_n, pu_sel, keep, crc, fin, rdy, pins_oe, ce_n, oe_n;
    logic config_clock_out, init_oe, done, user, pu_en, port_act, cvalid, cso_n, busy, init_n;
    logic [2:0] mode;
    logic [7:0] fdata, cdata;
    logic [AW-1:0] addr, a;
    int failures = 0;
    int total_checks = 0;
    int i;
    flash_cfg_master #(.ADDR_W(AW)) dut_u (.i_clk(clk), .i_srst(srst),
        .i_program_request_n(prog_n), .i_mode_select(mode), .i_pullup_disable_select(pu_sel),
        .i_readwrite_select_n(1'b0), .i_chip_select_in_n(1'b0),
        .i_keep_parallel_port(keep), .i_flash_data(fdata), .i_crc_error(crc),
        .i_load_finished(fin), .o_flash_addr(addr), .o_flash_pins_oe(pins_oe),
        .o_flash_chip_enable_n(ce_n), .o_flash_output_enable_n(oe_n),
        .o_flash_write_enable_n(), .o_flash_byte_mode_n(), .o_config_clock_out(config_clock_out),
        .o_chip_select_out_n(cso_n), .o_busy(busy), .o_init_status_n_out(init_n),
        .o_init_status_oe(init_oe),
        .o_done(done), .o_mode_pins_user(user), .o_pullups_enable(pu_en),
        .o_parallel_port_active(port_act), .o_cfg_data(cdata), .o_cfg_valid(cvalid),
        .i_cfg_ready(rdy));
    flash_model #(.ADDR_W(AW)) flash_u (.i_addr(addr), .i_ce_n(ce_n), .i_oe_n(oe_n),
        .o_data(fdata));
    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Every check goes through here; an unknown bit matches only an unknown bit.
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Takes one byte from the consumer side; ready is driven by the caller and dropped only for the stall check.
    task automatic pop(input logic [7:0] exp);
        int n;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (cvalid === 1'b1 && rdy) break;
        end
        cmp({cvalid, cdata}, {1'b1, exp});
    endtask
    // Pulses program request with a new mode, then waits for loading to begin.
    task automatic start(input logic [2:0] m, input logic exp);
        int n;
        mode <= m;
        prog_n <= 1'b0;
        repeat (4) @(posedge clk);
        prog_n <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (pins_oe === 1'b1) break;
        end
        cmp(pins_oe, exp);
    endtask
    // Main sequence.
    initial begin
        srst = 1'b1;
        prog_n = 1'b0;
        mode = 3'h2;
        pu_sel = 1'b0;
        keep = 1'b1;
        crc = 1'b0;
        fin = 1'b0;
        rdy = 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        start(flash_cfg_pkg::MODE_FLASH_UP, 1'b1);
        cmp(init_oe, 1'b0);
        cmp(pu_en, 1'b1);
        cmp(cso_n, 1'b1);
        cmp(busy, 1'b0);
        cmp(init_n, 1'b0);
        for (i = 0; i < 6; i++) pop(i[7:0] ^ 8'h3c);
        // A stalled consumer must freeze the address once the buffer is full.
        rdy <= 1'b0;
        repeat (120) @(posedge clk);
        a = addr;
        repeat (20) @(posedge clk);
        cmp(addr, a);
        cmp(cvalid, 1'b1);
        rdy <= 1'b1;
        for (i = 6; i < 30; i++) pop(i[7:0] ^ 8'h3c);
        fin <= 1'b1;
        @(posedge clk);
        fin <= 1'b0;
        repeat (2) @(posedge clk);
        cmp(done, 1'b1);
        cmp(pins_oe, 1'b0);
        cmp(user, 1'b1);
        cmp(port_act, 1'b1);
        cmp(pu_en, 1'b0);
        // Downward load; a late mode change must not matter.
        keep <= 1'b0;
        pu_sel <= 1'b1;
        start(flash_cfg_pkg::MODE_FLASH_DOWN, 1'b1);
        mode <= 3'h2;
        cmp(pu_en, 1'b0);
        for (i = 0; i < 5; i++) pop((8'hff - i[7:0]) ^ 8'h3c);
        crc <= 1'b1;
        @(posedge clk);
        crc <= 1'b0;
        repeat (2) @(posedge clk);
        cmp(init_oe, 1'b1);
        cmp(done, 1'b0);
        // Only two mode codes start a load.
        for (i = 0; i < 8; i++) begin
            start(i[2:0], i[2:1] == 2'b01);
            cmp(init_oe, i[2:1] != 2'b01);
        end
        wrap_up();
    end
    // Watchdog well beyond the under a thousand cycles the sequence needs.
    initial begin
        #1000000;
        failures++;
        wrap_up();
    end
endmodule // test_flash_cfg_master
`default_nettype wire
